/* hw/brg_pkg.sv */
package brg_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [31:0] IDX_COMPARE_0 = 32'hffff_f084;
    localparam logic [31:0] IDX_PRESCALE_MODE_0 = 32'hffff_f086;
    localparam logic [31:0] IDX_COMPARE_1 = 32'hffff_f094;
    localparam logic [31:0] IDX_PRESCALE_MODE_1 = 32'h0fff_f096;
    localparam logic [31:0] IDX_COMPARE_2 = 32'h0fff_f0a4;
    localparam logic [31:0] IDX_PRESCALE_MODE_2 = 32'h0fff_f0a6;
    localparam logic [31:0] IDX_CLOCK_SELECT = 32'hffff_f0b0;
    localparam logic [31:0] IDX_STATUS = 32'hffff_f0b4;
    localparam int IDX_W = 10;

    // Field positions and reset values.
    localparam int COUNT_EN_POS = 7;
    localparam int PRESCALE_LSB = 0;
    localparam int ASYNC_SEL_LSB = 0;
    localparam int SYNC_SEL_LSB = 8;
    localparam int STATUS_LEVEL_LSB = 0;
    localparam int STATUS_RUN_LSB = 8;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [1:0] SYNC_SEL_SYSCLK = 2'h0;
    localparam logic [7:0] TIMER_START = 8'h00;
    localparam logic [4:0] PRESCALE_START = 5'h00;

    typedef struct packed {
        logic enable;
        logic [2:0] prescale;
        logic [7:0] compare;
    } brg_cfg_t;

    // Low prescaler bits that must all be one for a count-clock tick.
    function automatic logic [4:0] presc_mask(input logic [2:0] sel);
        presc_mask = sel[2] ? 5'h1f : ((5'h02 << sel) - 5'h01);
    endfunction

    function automatic logic reg_hit(input logic [IDX_W-1:0] word,
                                     input logic [31:0] idx);
        reg_hit = (word == idx[IDX_W-1:0]);
    endfunction

endpackage

/* hw/brg_gen.sv */
`timescale 1ns/1ps
module brg_gen (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Configuration from the register file.
    input brg_pkg::brg_cfg_t cfg,
    // Generator state.
    output logic gen_level,
    output logic gen_pulse,
    output logic gen_running
);

    logic [4:0] presc_reg;
    logic [7:0] timer_reg;
    logic tick;
    logic restart;
    logic [15:0] gap_reg;
    logic gap_ok_reg;
    brg_pkg::brg_cfg_t cfg_last_reg;

    assign tick = cfg.enable &&
        ((presc_reg & brg_pkg::presc_mask(cfg.prescale))
         == brg_pkg::presc_mask(cfg.prescale)); // [RULE_10]
    // Compare zero wraps to 255, which gives a count of 256.
    assign restart = tick && (timer_reg == cfg.compare - 8'h01); // [RULE_07]

    always_ff @(posedge ref_clk) begin
        if (reset || !cfg.enable) begin
            presc_reg <= brg_pkg::PRESCALE_START; // [RULE_09]
        end else begin
            presc_reg <= presc_reg + 5'h01; // [RULE_04]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || !cfg.enable) begin
            timer_reg <= brg_pkg::TIMER_START; // [RULE_09]
        end else if (restart) begin
            timer_reg <= brg_pkg::TIMER_START; // [RULE_12]
        end else if (tick) begin
            timer_reg <= timer_reg + 8'h01; // [RULE_04]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || !cfg.enable) begin
            gen_level <= 1'b0;
            gen_pulse <= 1'b0;
            gen_running <= 1'b0;
        end else begin
            gen_level <= gen_level ^ restart; // [RULE_12]
            gen_pulse <= restart && !gen_level; // [RULE_12]
            gen_running <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        cfg_last_reg <= cfg;
        if (reset || restart) begin
            gap_reg <= 16'h0000;
        end else begin
            gap_reg <= gap_reg + 16'h0001;
        end
        if (reset || !cfg.enable || cfg != cfg_last_reg) begin
            gap_ok_reg <= 1'b0;
        end else if (restart) begin
            gap_ok_reg <= 1'b1;
        end
    end

    a_restart_spacing: assert property (@(posedge ref_clk) disable iff (reset)
        (restart && gap_ok_reg && cfg == cfg_last_reg) |->
        (gap_reg + 16'h0001 == ({8'h00, cfg.compare - 8'h01} + 16'h0001)
            << ($countones(brg_pkg::presc_mask(cfg.prescale)))))
        else $error("restart spacing is not k times prescale"); // [RULE_05]
    a_toggle_on_restart: assert property (@(posedge ref_clk) disable iff (reset)
        restart |=> (gen_level != $past(gen_level)))
        else $error("output did not toggle on restart"); // [RULE_12]
    a_stop_holds: assert property (@(posedge ref_clk) disable iff (reset)
        !cfg.enable |=> (timer_reg == 8'h00 && !gen_level && !gen_pulse))
        else $error("stopped generator still active"); // [RULE_09]
    a_zero_is_256: assert property (@(posedge ref_clk) disable iff (reset)
        (restart && cfg.compare == 8'h00) |-> timer_reg == 8'hff)
        else $error("compare zero did not count 256"); // [RULE_07]

endmodule

/* hw/brg_top.sv */
`timescale 1ns/1ps
// Overview of operation
// RULE_01 - Each serial channel takes its clock from a generator or the system clock, alone.
// RULE_02 - Async channels choose with one select bit, clocked channels with a two-bit field.
// RULE_03 - A channel has a single clock enable that serves transmit and receive alike.
// RULE_04 - Each generator is a prescaler, an 8-bit timer and a compare register on ref_clk.
// RULE_05 - For async use the rate is clock / (2 k 2^m 16 2), the 16 done by the channel.
// RULE_06 - For clocked serial use the rate is clock / (2 k 2^m 2).
// RULE_07 - The count k runs from 1 to 256, and a compare value of zero means 256.
// RULE_08 - Each compare register is an 8-bit read/write register written by byte lane 0.
// RULE_09 - The count enable bit stops the timer when 0 and lets it count when 1.
// RULE_10 - Prescale select 0 to 3 give clock /2 to /16, and any value with bit 2 set gives /32.
// RULE_11 - Software picks settings whose baud error stays within about 2.3 percent.
// RULE_12 - The timer restarts when it reaches the compare value and its output toggles.
module brg_top #(
    parameter int GEN_N = 3,
    parameter int ASYNC_N = 2,
    parameter int SYNC_N = 4,
    parameter int ADDR_W = 12
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial clock enables for the channels.
    output logic [ASYNC_N-1:0] async_clk_en,
    output logic [SYNC_N-1:0] sync_clk_en,
    // Generator output levels.
    output logic [GEN_N-1:0] gen_level
);

    localparam logic [31:0] IDX_COMPARE [0:2] = '{
        brg_pkg::IDX_COMPARE_0, brg_pkg::IDX_COMPARE_1, brg_pkg::IDX_COMPARE_2};
    localparam logic [31:0] IDX_MODE [0:2] = '{
        brg_pkg::IDX_PRESCALE_MODE_0, brg_pkg::IDX_PRESCALE_MODE_1,
        brg_pkg::IDX_PRESCALE_MODE_2};

    brg_pkg::brg_cfg_t cfg_reg [GEN_N];
    logic [ASYNC_N-1:0] async_clock_select_reg;
    logic [1:0] sync_clock_select_reg [SYNC_N];
    logic [GEN_N-1:0] gen_pulse;
    logic [GEN_N-1:0] gen_running;
    logic [31:0] prdata_next;
    logic [GEN_N-1:0] hit_compare;
    logic [GEN_N-1:0] hit_mode;
    logic hit_select;
    logic hit_status;
    logic mapped;
    logic access;
    logic complete;
    logic wr;
    logic [brg_pkg::IDX_W-1:0] word;

    assign word = paddr[brg_pkg::IDX_W+1:2];
    assign access = psel && penable;
    assign complete = access && pready;
    assign wr = complete && pwrite && mapped;

    // Address decode.
    always_comb begin
        for (int g = 0; g < GEN_N; g++) begin
            hit_compare[g] = brg_pkg::reg_hit(word, IDX_COMPARE[g]);
            hit_mode[g] = brg_pkg::reg_hit(word, IDX_MODE[g]);
        end
        hit_select = brg_pkg::reg_hit(word, brg_pkg::IDX_CLOCK_SELECT);
        hit_status = brg_pkg::reg_hit(word, brg_pkg::IDX_STATUS);
        mapped = (paddr[1:0] == 2'h0) &&
            (|hit_compare || |hit_mode || hit_select || hit_status);
    end

    // Read data mux; unused bits read as zero.
    always_comb begin
        prdata_next = 32'h0000_0000;
        for (int g = 0; g < GEN_N; g++) begin
            if (hit_compare[g]) begin
                prdata_next[7:0] = cfg_reg[g].compare; // [RULE_08]
            end
            if (hit_mode[g]) begin
                prdata_next[brg_pkg::COUNT_EN_POS] = cfg_reg[g].enable;
                prdata_next[brg_pkg::PRESCALE_LSB +: 3] = cfg_reg[g].prescale;
            end
            if (hit_status) begin
                prdata_next[brg_pkg::STATUS_LEVEL_LSB + g] = gen_level[g];
                prdata_next[brg_pkg::STATUS_RUN_LSB + g] = gen_running[g];
            end
        end
        if (hit_select) begin
            prdata_next[brg_pkg::ASYNC_SEL_LSB +: ASYNC_N] = async_clock_select_reg;
            for (int j = 0; j < SYNC_N; j++) begin
                prdata_next[brg_pkg::SYNC_SEL_LSB + 2*j +: 2] = sync_clock_select_reg[j];
            end
        end
    end

    // One wait state: pready rises in the second access cycle.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pready <= 1'b0;
        end else begin
            pready <= access && !pready;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            prdata <= (pwrite || !mapped) ? 32'h0000_0000 : prdata_next;
            pslverr <= !mapped;
        end
    end

    // Generator configuration registers.
    always_ff @(posedge ref_clk) begin
        for (int g = 0; g < GEN_N; g++) begin
            if (reset) begin
                cfg_reg[g].compare <= brg_pkg::COMPARE_RESET;
                cfg_reg[g].enable <= brg_pkg::MODE_RESET[brg_pkg::COUNT_EN_POS];
                cfg_reg[g].prescale <= brg_pkg::MODE_RESET[brg_pkg::PRESCALE_LSB +: 3];
            end else if (wr && pstrb[0]) begin
                if (hit_compare[g]) begin
                    cfg_reg[g].compare <= pwdata[7:0]; // [RULE_08]
                end
                if (hit_mode[g]) begin
                    cfg_reg[g].enable <= pwdata[brg_pkg::COUNT_EN_POS]; // [RULE_09]
                    cfg_reg[g].prescale <= pwdata[brg_pkg::PRESCALE_LSB +: 3]; // [RULE_10]
                end
            end
        end
    end

    // Channel clock source select register.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            async_clock_select_reg <= '0;
            for (int j = 0; j < SYNC_N; j++) begin
                sync_clock_select_reg[j] <= brg_pkg::SYNC_SEL_SYSCLK;
            end
        end else if (wr && hit_select) begin
            if (pstrb[0]) begin
                async_clock_select_reg <=
                    pwdata[brg_pkg::ASYNC_SEL_LSB +: ASYNC_N]; // [RULE_02]
            end
            if (pstrb[1]) begin
                for (int j = 0; j < SYNC_N; j++) begin
                    sync_clock_select_reg[j] <=
                        pwdata[brg_pkg::SYNC_SEL_LSB + 2*j +: 2]; // [RULE_02]
                end
            end
        end
    end

    for (genvar g = 0; g < GEN_N; g++) begin : gen_brg
        brg_gen u_gen (
            .ref_clk(ref_clk),
            .reset(reset),
            .cfg(cfg_reg[g]),
            .gen_level(gen_level[g]),
            .gen_pulse(gen_pulse[g]),
            .gen_running(gen_running[g])
        ); // [RULE_04]
    end

    function automatic logic sync_src(input logic [1:0] sel,
                                      input logic [GEN_N-1:0] pulse);
        if (sel == brg_pkg::SYNC_SEL_SYSCLK) begin
            sync_src = 1'b1;
        end else if (int'(sel) <= GEN_N) begin
            sync_src = pulse[sel - 2'h1];
        end else begin
            sync_src = 1'b0;
        end
    endfunction

    // One enable per channel feeds both its transmit and receive sections.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            async_clk_en <= '0;
            sync_clk_en <= '0;
        end else begin
            for (int i = 0; i < ASYNC_N; i++) begin
                async_clk_en[i] <= async_clock_select_reg[i] ?
                    gen_pulse[i % GEN_N] : 1'b1; // [RULE_01] [RULE_03] [RULE_05]
            end
            for (int j = 0; j < SYNC_N; j++) begin
                sync_clk_en[j] <= sync_src(sync_clock_select_reg[j],
                    gen_pulse); // [RULE_01] [RULE_03] [RULE_06]
            end
        end
    end

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_wait;
        psel && penable && !pready;
    endsequence

    a_apb_wait_state: assert property (@(posedge ref_clk) disable iff (reset)
        s_setup ##1 s_wait |=> pready)
        else $error("pready not high after one wait cycle");
    a_unmapped_error: assert property (@(posedge ref_clk) disable iff (reset)
        (complete && !mapped) |-> pslverr)
        else $error("unmapped access without error");
    a_compare_write: assert property (@(posedge ref_clk) disable iff (reset)
        (wr && pstrb[0] && hit_compare[0]) |=>
        cfg_reg[0].compare == $past(pwdata[7:0]))
        else $error("compare write did not land"); // [RULE_08]
    a_enable_write: assert property (@(posedge ref_clk) disable iff (reset)
        (wr && pstrb[0] && hit_mode[1]) |=>
        cfg_reg[1].enable == $past(pwdata[brg_pkg::COUNT_EN_POS]))
        else $error("count enable write did not land"); // [RULE_09]
    a_sync_sysclk: assert property (@(posedge ref_clk) disable iff (reset)
        (sync_clock_select_reg[0] == brg_pkg::SYNC_SEL_SYSCLK) ##1
        (sync_clock_select_reg[0] == brg_pkg::SYNC_SEL_SYSCLK) |-> sync_clk_en[0])
        else $error("system clock source not passed through"); // [RULE_01]
    a_async_from_gen: assert property (@(posedge ref_clk) disable iff (reset)
        async_clock_select_reg[0] |=> async_clk_en[0] == $past(gen_pulse[0]))
        else $error("async channel not fed by its generator"); // [RULE_02]
    a_sync_from_gen: assert property (@(posedge ref_clk) disable iff (reset)
        (sync_clock_select_reg[0] == 2'h3) |=> sync_clk_en[0] == $past(gen_pulse[2]))
        else $error("clocked channel not fed by chosen generator"); // [RULE_06]

endmodule

/* bench/brg_chan_model.sv */
`timescale 1ns/1ps
module brg_chan_model #(
    parameter int N = 2,
    parameter int OVER = 16
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // One serial clock enable per channel.
    input wire logic [N-1:0] clk_en,
    // Bit periods completed by each channel.
    output logic [N-1:0][15:0] bits
);
    logic [N-1:0][4:0] phase_reg;

    // Transmit and receive step on the same enable, so both run at one rate.
    // A bit lasts OVER enables: sixteen for async use, one for clocked use.
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < N; i++) begin
            if (reset) begin
                phase_reg[i] <= 5'h00;
                bits[i] <= 16'h0000;
            end else if (clk_en[i]) begin
                if (phase_reg[i] == 5'(OVER - 1)) begin
                    phase_reg[i] <= 5'h00;
                    bits[i] <= bits[i] + 16'h0001;
                end else begin
                    phase_reg[i] <= phase_reg[i] + 5'h01;
                end
            end
        end
    end
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic ref_clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [1:0] async_clk_en;
    logic [3:0] sync_clk_en;
    logic [2:0] gen_level;
    logic [8:0] probe, probe_q;
    logic [1:0][15:0] async_bits;
    logic [3:0][15:0] sync_bits;
    int n_errors = 0;
    int compares = 0;

    brg_top uut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .async_clk_en(async_clk_en),
        .sync_clk_en(sync_clk_en), .gen_level(gen_level));
    brg_chan_model #(.N(2), .OVER(16)) async_side (.ref_clk(ref_clk), .reset(reset),
        .clk_en(async_clk_en), .bits(async_bits));
    brg_chan_model #(.N(4), .OVER(1)) sync_side (.ref_clk(ref_clk), .reset(reset),
        .clk_en(sync_clk_en), .bits(sync_bits));

    assign probe = {gen_level, sync_clk_en, async_clk_en};
    always @(posedge ref_clk) probe_q <= probe;

    function automatic logic [11:0] ba(input logic [31:0] idx);
        ba = {idx[9:0], 2'b00};
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up;
        if (n_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, ba(idx), d, r, e);
    endtask

    task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp,
                      input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(name, r, exp);
        chk(name, {31'h0000_0000, e}, {31'h0000_0000, exp_err});
    endtask

    task automatic rise_wait(input int idx, output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (!(probe[idx] === 1'b1 && probe_q[idx] === 1'b0) && n < 5000);
    endtask

    task automatic period(input string name, input int idx, input int exp);
        int n;
        rise_wait(idx, n);
        rise_wait(idx, n);
        rise_wait(idx, n);
        chk(name, n, exp);
    endtask

    task automatic gen_cfg(input int g, input logic [7:0] k, input logic [2:0] m);
        logic [31:0] cmp [3] = '{brg_pkg::IDX_COMPARE_0, brg_pkg::IDX_COMPARE_1,
                                 brg_pkg::IDX_COMPARE_2};
        logic [31:0] mode [3] = '{brg_pkg::IDX_PRESCALE_MODE_0,
                                  brg_pkg::IDX_PRESCALE_MODE_1, brg_pkg::IDX_PRESCALE_MODE_2};
        wr(cmp[g], {24'h0000_00, k});
        wr(mode[g], {24'h0000_00, 5'h10, m});
    endtask

    task automatic t_reset;
        rd("compare0", ba(brg_pkg::IDX_COMPARE_0), 32'h0000_0000, 1'b0);
        rd("mode0", ba(brg_pkg::IDX_PRESCALE_MODE_0), 32'h0000_0000, 1'b0);
        rd("mode1", ba(brg_pkg::IDX_PRESCALE_MODE_1), 32'h0000_0000, 1'b0);
        rd("mode2", ba(brg_pkg::IDX_PRESCALE_MODE_2), 32'h0000_0000, 1'b0);
        repeat (4) begin
            @(posedge ref_clk);
            chk("sysclk enables", {26'h0, probe[5:0]}, 32'h0000_003f);
        end
    endtask

    task automatic t_regs;
        wr(brg_pkg::IDX_COMPARE_1, 32'h0000_00a5);
        rd("compare1", ba(brg_pkg::IDX_COMPARE_1), 32'h0000_00a5, 1'b0);
        wr(brg_pkg::IDX_PRESCALE_MODE_2, 32'h0000_0085);
        rd("mode2", ba(brg_pkg::IDX_PRESCALE_MODE_2), 32'h0000_0085, 1'b0);
        rd("unmapped", 12'h000, 32'h0000_0000, 1'b1);
    endtask

    task automatic t_prescale;
        wr(brg_pkg::IDX_CLOCK_SELECT, 32'h0000_0100);
        for (int m = 0; m < 8; m++) begin
            gen_cfg(0, 8'h01, 3'(m));
            period("prescale", 2, 4 << (m > 3 ? 4 : m));
        end
        gen_cfg(0, 8'h00, 3'h0);
        period("count 256", 2, 1024);
        gen_cfg(0, 8'h03, 3'h1);
        period("count 3", 2, 24);
        period("level", 6, 24);
    endtask

    task automatic t_select;
        logic [15:0] b0;
        logic [15:0] b1;
        gen_cfg(0, 8'h03, 3'h0);
        gen_cfg(1, 8'h02, 3'h0);
        gen_cfg(2, 8'h05, 3'h0);
        wr(brg_pkg::IDX_CLOCK_SELECT, 32'h0000_1b03);
        period("async0", 0, 12);
        period("async1", 1, 8);
        period("sync0", 2, 20);
        period("sync1", 3, 8);
        period("sync2", 4, 12);
        @(posedge ref_clk);
        chk("sync3 sysclk", probe[5], 1'b1);
        period("level1", 7, 8);
        period("level2", 8, 20);
        rd("select", ba(brg_pkg::IDX_CLOCK_SELECT), 32'h0000_1b03, 1'b0);
        b0 = async_bits[0];
        b1 = async_bits[1];
        repeat (768) @(posedge ref_clk);
        chk("async0 bits", 16'(async_bits[0] - b0), 32'h0000_0004);
        chk("async1 bits", 16'(async_bits[1] - b1), 32'h0000_0006);
        gen_cfg(1, 8'h51, 3'h0);
        period("async1 rate", 1, 324);
    endtask

    task automatic t_stop;
        logic [15:0] b;
        logic [31:0] r;
        logic e;
        wr(brg_pkg::IDX_PRESCALE_MODE_0, 32'h0000_0000);
        repeat (4) @(posedge ref_clk);
        b = sync_bits[2];
        repeat (100) @(posedge ref_clk);
        chk("stopped bits", sync_bits[2], b);
        chk("stopped level", gen_level[0], 1'b0);
        apb(1'b0, ba(brg_pkg::IDX_STATUS), 32'h0000_0000, r, e);
        chk("status run", {29'h0000_0000, r[10:8]}, 32'h0000_0006);
        chk("status level", r[0], 1'b0);
        gen_cfg(0, 8'h01, 3'h0);
        period("restart", 4, 4);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_regs();
        t_prescale();
        t_select();
        t_stop();
        wrap_up();
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        n_errors++;
        wrap_up();
    end
endmodule
